//--- lgt_logic_tile.sv
// Eight-cell logic tile with its AHB-Lite configuration port
// What this block does
// - Tile holds eight cells, each one lookup table and one flop.
// - Lookup table is a 16x1 table indexed by four inputs.
// - Cell flop is D-type with optional enable and set/reset.
// - Global reset holds every flop clear until configuration is done.
// - Each cell has fast carry logic for arithmetic chains.
// - One clock enable serves all cells of the tile.
// - One set/reset for the tile, async or sync by choice.
// - Tile clock comes from one of eight buffers or routing.
// - Each cell output shows the table result or the flop.
// - Unused set/reset never touches flops, apart from config clear.
// - Wake-up state of every flop is reset, whatever set variant.
// - Set/reset from even buffers only, enable from odd only.
//
// Local design decisions: the address map and the AHB-Lite register port.

`timescale 1ns/1ps
`default_nettype none

module lgt_logic_tile
  import lgt_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                en,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic [GB_N-1:0]     global_buffer,
  input  wire logic                route_clk,
  input  wire logic                route_ce,
  input  wire logic                route_sr,
  input  wire logic [4*CELLS-1:0]  cell_data,
  input  wire logic                carry_chain_in,
  output logic [CELLS-1:0]         cell_out,
  output logic                     carry_chain_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int unsigned PIN_W = GB_N + 3 + 4 * CELLS + 1;

  logic [PIN_W-1:0]     pin_s1_r;
  logic [PIN_W-1:0]     pin_s2_r;
  logic [GB_N-1:0]      gb_s;
  logic                 rclk_s;
  logic                 rce_s;
  logic                 rsr_s;
  logic [4*CELLS-1:0]   din_s;
  logic                 cin_s;
  logic [CTRL_W-1:0]    ctrl_r;
  logic [15:0]          mode_r;
  logic [TBL_W-1:0]     tbl_r [CELLS];
  logic                 wr_pend_r;
  logic [5:0]           wr_idx_r;
  logic                 hreadyout_r;
  logic                 hresp_r;
  logic [31:0]          hrdata_r;
  logic [31:0]          rd_word;
  logic                 take;
  logic                 sel_clk;
  logic                 prev_clk_r;
  logic                 ce_sig;
  logic                 sr_sig;
  lgt_ctl_t             ctl;
  logic [CELLS-1:0]     comb_w;
  logic [CELLS-1:0]     q_w;
  logic [CELLS-1:0]     out_w;
  logic [CELLS:0]       carry_w;
  logic [CELLS-1:0]     cell_out_r;
  logic                 carry_out_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Every pin other than the bus and en crosses two flops; only the second stage is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else if (en) begin
      pin_s1_r <= {global_buffer, route_clk, route_ce, route_sr,
                   cell_data, carry_chain_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {gb_s, rclk_s, rce_s, rsr_s, din_s, cin_s} = pin_s2_r;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Address phase is taken only with en high; zero wait states
  assign take = hsel && htrans[1] && hready && en;

  // Writes are held to the data phase; only whole words count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 6'h00;
    end else if (en) begin
      wr_pend_r <= take && hwrite && (hsize == SIZE_WORD) &&
                   (haddr[31:8] == 24'h000000);
      wr_idx_r  <= haddr[7:2];
    end
  end

  // Ready always high, response always OKAY; both kept in flops
  // so that every output of the tile leaves from a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else if (en) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // Read word chosen from the address phase; unmapped reads as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[31:8] == 24'h000000) begin
      if (haddr[7:2] == IDX_CTRL) begin
        rd_word[CTRL_W-1:0] = ctrl_r;
      end else if (haddr[7:2] == IDX_MODE) begin
        rd_word[15:0] = mode_r;
      end else if (haddr[7:2] >= IDX_TBL0 &&
                   haddr[7:2] < IDX_STAT) begin
        rd_word[TBL_W-1:0] = tbl_r[3'(haddr[7:2] - IDX_TBL0)];
      end else if (haddr[7:2] == IDX_STAT) begin
        rd_word[STAT_Q +: CELLS]   = q_w;
        rd_word[STAT_OUT +: CELLS] = cell_out_r;
        rd_word[STAT_CARRY]        = carry_out_r;
        rd_word[STAT_DONE]         = ctrl_r[CTRL_DONE];
      end
    end
  end

  // Read data registered so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (en && take && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  assign hrdata = hrdata_r;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Control word: done flag and the shared control sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (en && wr_pend_r && wr_idx_r == IDX_CTRL) begin
      ctrl_r <= hwdata[CTRL_W-1:0];
    end
  end

  // Output select and set variant, one bit per cell each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_RST;
    end else if (en && wr_pend_r && wr_idx_r == IDX_MODE) begin
      mode_r <= hwdata[15:0];
    end
  end

  // ****************************************************************
  // Shared clock, enable and set/reset
  // ****************************************************************
  // clock source
  // Tile edge is a rising edge of the chosen source seen on hclk
  assign sel_clk = ctrl_r[CTRL_CKRT] ? rclk_s :
                   gb_s[ctrl_r[CTRL_CKSEL +: 3]];

  // Previous level of the chosen clock for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_clk_r <= 1'b0;
    end else if (en) begin
      prev_clk_r <= sel_clk;
    end
  end

  // even and odd sources
  // Enable taps odd buffers only, set/reset even ones only
  assign ce_sig = ctrl_r[CTRL_CERT] ? rce_s :
                  gb_s[{ctrl_r[CTRL_CESEL +: 2], 1'b1}];
  assign sr_sig = ctrl_r[CTRL_SRRT] ? rsr_s :
                  gb_s[{ctrl_r[CTRL_SRSEL +: 2], 1'b0}];

  // one tile enable
  // One enable and one set/reset reach all cells together
  always_comb begin
    ctl.tick     = sel_clk && !prev_clk_r;
    ctl.ce       = !ctrl_r[CTRL_CEUSE] || ce_sig;
    ctl.sr       = ctrl_r[CTRL_SRUSE] && sr_sig;
    ctl.sr_async = ctrl_r[CTRL_SRASY];
    // global clear
    // Flops held clear until software marks configuration done
    ctl.greset   = !ctrl_r[CTRL_DONE];
  end

  // ****************************************************************
  // Cell array
  // ****************************************************************
  // carry entry
  assign carry_w[0] = cin_s;

  // eight cells
  // Each cell gets its table word, four inputs and the carry
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    lgt_cell_cfg_t cfg;

    // Table contents, one word per cell
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tbl_r[i] <= TBL_RST;
      end else if (en && wr_pend_r &&
                   wr_idx_r == IDX_TBL0 + 6'(i)) begin
        tbl_r[i] <= hwdata[TBL_W-1:0];
      end
    end

    assign cfg.table_bits = tbl_r[i];
    assign cfg.reg_out    = mode_r[MODE_REG + i];
    assign cfg.set_val    = mode_r[MODE_SET + i];

    lgt_slice_cell u_cell (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .en        (en),
      .cfg       (cfg),
      .ctl       (ctl),
      .cell_in   (din_s[4*i +: 4]),
      .carry_in  (carry_w[i]),
      .comb_out  (comb_w[i]),
      .q_r       (q_w[i]),
      .carry_out (carry_w[i+1])
    );

    assign out_w[i] = cfg.reg_out ? q_w[i] : comb_w[i];
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Outputs re-timed by one flop, costing a cycle of latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cell_out_r  <= '0;
      carry_out_r <= 1'b0;
    end else if (en) begin
      cell_out_r  <= out_w;
      carry_out_r <= carry_w[CELLS];
    end
  end

  assign cell_out        = cell_out_r;
  assign carry_chain_out = carry_out_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Combinational cell 0 shows its table entry a cycle later
  a_table_lookup: assert property (
    en && !mode_r[MODE_REG] |=>
      cell_out[0] == $past(tbl_r[0][din_s[3:0]]))
    else $error("cell 0 output differs from its table entry");

  // Registered mode shows the flop a cycle later
  a_output_reg: assert property (
    en && mode_r[MODE_REG + 1] |=> cell_out[1] == $past(q_w[1]))
    else $error("cell 1 registered output differs from flop");

  // Not configured means every flop reads zero
  a_wake_clear: assert property (
    en && !ctrl_r[CTRL_DONE] |=> q_w == '0)
    else $error("flops not cleared before configuration done");

  // With no tile edge and no set/reset, flops stay put
  a_sr_unused: assert property (
    ctrl_r[CTRL_DONE] && !ctl.tick && !ctl.sr |=> $stable(q_w))
    else $error("flop changed without edge or set/reset");

  // Enable low at an edge keeps all flops
  a_ce_hold: assert property (
    ctrl_r[CTRL_DONE] && ctl.tick && !ctl.ce && !ctl.sr |=>
      $stable(q_w))
    else $error("flop loaded while tile enable low");

  // Async set/reset forces the set variant a cycle later, with no tile edge
  a_sr_async: assert property (
    en && ctrl_r[CTRL_DONE] && ctl.sr && ctl.sr_async |=>
      q_w == $past(mode_r[MODE_SET +: CELLS]))
    else $error("async set/reset did not apply");

  // Sync set/reset waits for a tile edge
  a_sr_sync: assert property (
    en && ctrl_r[CTRL_DONE] && ctl.sr && !ctl.sr_async &&
      !ctl.tick && !ctl.ce |=> $stable(q_w))
    else $error("sync set/reset acted without a tile edge");

  // Edge with enable loads each flop from its table
  a_flop_load: assert property (
    en && ctrl_r[CTRL_DONE] && ctl.tick && ctl.ce && !ctl.sr |=>
      q_w == $past(comb_w))
    else $error("flop did not load table result");

  // One rise of the chosen source gives exactly one tile edge
  a_clock_edge: assert property (
    en && ctl.tick |=> !ctl.tick)
    else $error("tile edge repeated without a new rise");

  // Cell 0 carries out whenever both its operand inputs are high
  a_carry_chain: assert property (
    en && din_s[1] && din_s[2] |-> carry_w[1] == 1'b1)
    else $error("cell 0 carry out wrong");

  // Bus never stalls and never errors
  a_bus_ready: assert property (
    hreadyout && !hresp)
    else $error("bus slave not ready or erroring");

endmodule

`default_nettype wire

//--- lgt_slice_cell.sv
// Shared constants and types for the logic tile, plus one slice cell
package lgt_pkg;
  // ****************************************************************
  // Tile shape and bus constants
  // ****************************************************************
  localparam int unsigned CELLS      = 8;
  localparam int unsigned TBL_W      = 16;
  localparam int unsigned SEL_IN     = 4;
  localparam int unsigned GB_N       = 8;
  localparam logic [2:0]  SIZE_WORD  = 3'h2;
  localparam logic [1:0]  TRANS_NSEQ = 2'h2;
  // ****************************************************************
  // Register word indices (byte address is index times four)
  // ****************************************************************
  localparam logic [5:0]  IDX_CTRL   = 6'h00;
  localparam logic [5:0]  IDX_MODE   = 6'h01;
  localparam logic [5:0]  IDX_TBL0   = 6'h02;
  localparam logic [5:0]  IDX_STAT   = 6'h0A;
  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_DONE   = 0;
  localparam int CTRL_SRUSE  = 1;
  localparam int CTRL_SRASY  = 2;
  localparam int CTRL_CEUSE  = 3;
  localparam int CTRL_CKSEL  = 4;
  localparam int CTRL_CKRT   = 7;
  localparam int CTRL_SRSEL  = 8;
  localparam int CTRL_SRRT   = 10;
  localparam int CTRL_CESEL  = 11;
  localparam int CTRL_CERT   = 13;
  localparam int CTRL_W      = 14;
  // Mode register fields: output select, then set variant per cell
  localparam int MODE_REG    = 0;
  localparam int MODE_SET    = 8;
  // Status register fields
  localparam int STAT_Q      = 0;
  localparam int STAT_OUT    = 8;
  localparam int STAT_CARRY  = 16;
  localparam int STAT_DONE   = 17;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [15:0]       MODE_RST = 16'h0000;
  localparam logic [TBL_W-1:0]  TBL_RST  = 16'h0000;

  // Per-cell configuration
  typedef struct packed {
    logic [TBL_W-1:0] table_bits;
    logic             reg_out;
    logic             set_val;
  } lgt_cell_cfg_t;

  // Controls shared by every cell of the tile
  typedef struct packed {
    logic tick;
    logic ce;
    logic sr;
    logic sr_async;
    logic greset;
  } lgt_ctl_t;
endpackage

`timescale 1ns/1ps
`default_nettype none

module lgt_slice_cell
  import lgt_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          en,
  input  wire lgt_cell_cfg_t cfg,
  input  wire lgt_ctl_t      ctl,
  input  wire logic [3:0]    cell_in,
  input  wire logic          carry_in,
  output logic               comb_out,
  output logic               q_r,
  output logic               carry_out
);
  // table lookup
  // Any function of four inputs, read from a 16x1 table
  assign comb_out = cfg.table_bits[cell_in];

  // carry logic
  // Majority of two operand inputs and the incoming carry
  assign carry_out = (cell_in[1] & cell_in[2]) |
                     (carry_in & (cell_in[1] | cell_in[2]));

  // cell flop
  // Global clear beats set/reset, set/reset beats the enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= 1'b0;
    end else if (en) begin
      if (ctl.greset) begin
        q_r <= 1'b0;
      end else if (ctl.sr && (ctl.sr_async || ctl.tick)) begin
        q_r <= cfg.set_val;
      end else if (ctl.tick && ctl.ce) begin
        q_r <= comb_out;
      end
    end
  end
endmodule

`default_nettype wire

//--- lookup_logic_tile_bench.sv
// Self-checking bench for the eight-cell logic tile
`timescale 1ns/1ps
`default_nettype none

module lookup_logic_tile_bench
  import lgt_pkg::*;
;
  // ******************************
  // Signals and constants
  // ******************************
  logic               hclk;
  logic               hresetn;
  logic               en;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic               hready;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  logic [GB_N-1:0]    global_buffer;
  logic               route_clk;
  logic               route_ce;
  logic               route_sr;
  logic [4*CELLS-1:0] cell_data;
  logic               carry_chain_in;
  logic [CELLS-1:0]   cell_out;
  logic               carry_chain_out;
  int                 num_errors;
  int                 checks_done;
  int                 cyc;
  logic [31:0]        rd_val;
  logic [31:0]        v;
  logic               cin;
  logic [7:0]         q_exp;
  logic [7:0]         dq;
  logic [15:0]        tv;
  logic [31:0]        cv [4] = '{32'h22222222, 32'h66666666,
                                 32'h00000000, 32'h22600422};

  localparam logic [31:0] C_DONE  = 32'h1 << CTRL_DONE;
  localparam logic [31:0] C_SRUSE = 32'h1 << CTRL_SRUSE;
  localparam logic [31:0] C_SRASY = 32'h1 << CTRL_SRASY;
  localparam logic [31:0] C_CEUSE = 32'h1 << CTRL_CEUSE;
  localparam logic [31:0] C_CKRT  = 32'h1 << CTRL_CKRT;
  localparam logic [31:0] C_SRRT  = 32'h1 << CTRL_SRRT;
  localparam logic [31:0] C_CERT  = 32'h1 << CTRL_CERT;

  // One slave on the bus, so its ready is the bus ready
  assign hready = hreadyout;

  lgt_logic_tile DUT (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .en              (en),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hready),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .global_buffer   (global_buffer),
    .route_clk       (route_clk),
    .route_ce        (route_ce),
    .route_sr        (route_sr),
    .cell_data       (cell_data),
    .carry_chain_in  (carry_chain_in),
    .cell_out        (cell_out),
    .carry_chain_out (carry_chain_out)
  );

  // ******************************
  // Helpers
  // ******************************
  function automatic logic [31:0] ad(input logic [5:0] idx);
    ad = {24'h000000, idx, 2'h0};
  endfunction

  function automatic logic [15:0] tpat(input int i);
    tpat = 16'h6996 ^ (16'h0F0F << i);
  endfunction

  // Put one bit per cell on table input zero
  function automatic logic [31:0] spread(input logic [7:0] d);
    spread = 32'h0;
    for (int i = 0; i < CELLS; i++)
      spread[4*i] = d[i];
  endfunction

  // Majority ripple from cell 0 up to cell 7
  function automatic logic exp_carry(input logic [31:0] d, input logic c);
    logic x;
    x = c;
    for (int i = 0; i < CELLS; i++)
      x = (d[4*i+1] & d[4*i+2]) | (x & (d[4*i+1] | d[4*i+2]));
    exp_carry = x;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_q(input logic [7:0] e);
    chk({24'h0, cell_out}, {24'h0, e});
  endtask

  // Request held until ready is seen high; hsel stays up between calls
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= TRANS_NSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd_val, e);
  endtask

  // Longer than the four-edge pin-to-output path
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask

  task automatic tick_src(input int k, input logic b);
    if (k == GB_N)
      route_clk <= b;
    else
      global_buffer[k] <= b;
  endtask

  // Settle first so controls changed just before are synchronised
  task automatic clk_pulse;
    settle();
    tick_src(GB_N, 1'b1);
    settle();
    tick_src(GB_N, 1'b0);
    settle();
  endtask

  task automatic finish_test;
    $display("checks_done %0d num_errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Clock and hang guard; the run needs well under 20000 cycles
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ******************************
  // Test sequence
  // ******************************
  initial begin
    num_errors = 0;
    checks_done = 0;
    cyc = 0;
    hresetn = 1'b0;
    en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    hwdata = 32'h0;
    global_buffer = 8'h00;
    route_clk = 1'b0;
    route_ce = 1'b0;
    route_sr = 1'b0;
    cell_data = 32'h0;
    carry_chain_in = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ad(IDX_CTRL), {18'h0, CTRL_RST});
    rd(ad(IDX_MODE), {16'h0, MODE_RST});
    rd(ad(IDX_TBL0), {16'h0, TBL_RST});
    rd(ad(IDX_STAT), 32'h0);
    for (int i = 0; i < CELLS; i++)
      wr(ad(IDX_TBL0 + 6'(i)), {16'h0, tpat(i)});
    for (int i = 0; i < CELLS; i++)
      rd(ad(IDX_TBL0 + 6'(i)), {16'h0, tpat(i)});
    wr(ad(IDX_CTRL), C_DONE);
    for (int x = 0; x < TBL_W; x++) begin
      cell_data <= {CELLS{4'(x)}};
      settle();
      for (int i = 0; i < CELLS; i++) begin
        tv = tpat(i);
        dq[i] = tv[x];
      end
      chk_q(dq);
    end
    // Status is read-only; unmapped word reads zero
    wr(ad(IDX_STAT), 32'hFFFFFFFF);
    rd(ad(6'h0B), 32'h0);
    rd(ad(IDX_STAT), 32'h00030000 | {16'h0, dq, 8'h00});
    // ripple through all cells, both carry-in levels
    for (int j = 0; j < 8; j++) begin
      v = cv[j/2];
      cin = j[0];
      cell_data <= v;
      carry_chain_in <= cin;
      settle();
      chk({31'h0, carry_chain_out}, {31'h0, exp_carry(v, cin)});
    end
    // registered output from each clock source
    for (int i = 0; i < CELLS; i++)
      wr(ad(IDX_TBL0 + 6'(i)), 32'h0000AAAA);
    wr(ad(IDX_MODE), 32'h000000FF);
    cell_data <= 32'h0;
    q_exp = 8'h00;
    for (int k = 0; k <= GB_N; k++) begin
      wr(ad(IDX_CTRL), C_DONE | ((k == GB_N) ? C_CKRT
                                 : 32'(k) << CTRL_CKSEL));
      settle();
      dq = 8'hA5 ^ (8'h11 * 8'(k));
      cell_data <= spread(dq);
      settle();
      chk_q(q_exp);
      tick_src(k, 1'b1);
      settle();
      tick_src(k, 1'b0);
      settle();
      q_exp = dq;
      chk_q(q_exp);
    end
    // shared enable from odd buffers or routing
    for (int k = 0; k <= 4; k++) begin
      wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_CEUSE
         | ((k == 4) ? C_CERT : 32'(k) << CTRL_CESEL));
      dq = ~q_exp;
      cell_data <= spread(dq);
      global_buffer <= 8'h55;
      clk_pulse();
      chk_q(q_exp);
      if (k == 4)
        route_ce <= 1'b1;
      else
        global_buffer[2*k+1] <= 1'b1;
      clk_pulse();
      q_exp = dq;
      chk_q(q_exp);
      global_buffer <= 8'h00;
      route_ce <= 1'b0;
    end
    wr(ad(IDX_MODE), 32'h00000FFF);
    wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_SRRT);
    cell_data <= spread(8'h3C);
    clk_pulse();
    route_sr <= 1'b1;
    clk_pulse();
    chk_q(8'h3C);
    // asynchronous acts at once, synchronous waits for a tile edge
    wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_SRRT | C_SRUSE | C_SRASY);
    settle();
    chk_q(8'h0F);
    route_sr <= 1'b0;
    clk_pulse();
    chk_q(8'h3C);
    wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_SRRT | C_SRUSE);
    route_sr <= 1'b1;
    settle();
    chk_q(8'h3C);
    clk_pulse();
    chk_q(8'h0F);
    route_sr <= 1'b0;
    clk_pulse();
    for (int k = 0; k < 4; k++) begin
      wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_SRUSE | C_SRASY
         | 32'(k) << CTRL_SRSEL);
      global_buffer <= 8'h02 << (2*k);
      settle();
      chk_q(8'h3C);
      global_buffer <= 8'h01 << (2*k);
      settle();
      chk_q(8'h0F);
      global_buffer <= 8'h00;
      clk_pulse();
    end
    // configuration not done beats an active set
    route_sr <= 1'b1;
    wr(ad(IDX_CTRL), C_CKRT | C_SRRT | C_SRUSE | C_SRASY);
    settle();
    chk_q(8'h00);
    rd(ad(IDX_STAT), 32'h0);
    wr(ad(IDX_CTRL), C_DONE | C_CKRT | C_SRRT | C_SRUSE | C_SRASY);
    settle();
    chk_q(8'h0F);
    // Enable low freezes the tile: the source pulse is never seen
    en <= 1'b0;
    route_sr <= 1'b0;
    clk_pulse();
    en <= 1'b1;
    settle();
    chk_q(8'h0F);
    finish_test();
  end
endmodule

`default_nettype wire
